// *** hdl/spc_pkg.sv ***
// spc_pkg: shared constants and types for the sleep/idle power controller
package spc_pkg;

  // power-save instruction operand encoding
  localparam logic       SPC_MODE_SLEEP   = 1'h0;
  localparam logic       SPC_MODE_IDLE    = 1'h1;

  // wake restart delay, in system clocks (2 to 4 allowed)
  localparam int         SPC_RESUME_CYC   = 3;
  localparam logic [2:0] SPC_RESUME_LAST  = 3'(SPC_RESUME_CYC - 1);
  localparam logic [2:0] SPC_CNT_ZERO     = 3'h0;
  localparam logic [2:0] SPC_CNT_ONE      = 3'h1;

  // reset values of configuration state
  localparam logic       SPC_REG_STBY_RST = 1'h0;
  localparam logic       SPC_LPWR_RST     = 1'h0;
  localparam logic       SPC_CLKSEL_RST   = 1'h0;

  // index of the stop-in-idle bit in the first timer control word
  localparam int         SPC_TMR_STOP_IN_IDLE_POS = 13;
  localparam int         SPC_NPER         = 8;

  typedef enum logic [2:0] {
    SPC_RUN    = 3'h0,
    SPC_ENTER  = 3'h1,
    SPC_SLEEP  = 3'h2,
    SPC_IDLE   = 3'h3,
    SPC_RESUME = 3'h4
  } spc_state_t;

endpackage : spc_pkg

// *** hdl/spc_sync2.sv ***
// spc_sync2: two-flop synchroniser for asynchronous inputs
`timescale 1ns/100ps
module spc_sync2 (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  // data
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_reg;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= 1'h0;
      q_o      <= 1'h0;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end
endmodule : spc_sync2

// *** hdl/spc_periph_gate.sv ***
// spc_periph_gate: run enable for one peripheral in sleep/idle
`timescale 1ns/100ps
module spc_periph_gate (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  // mode
  input  wire logic in_sleep_i,
  input  wire logic in_idle_i,
  // peripheral configuration
  input  wire logic stop_in_idle_i,
  input  wire logic ext_clocked_i,
  // result
  output logic      run_o
);
  wire run_next = in_sleep_i ? ext_clocked_i : !(in_idle_i && stop_in_idle_i);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) run_o <= 1'h1;
    else       run_o <= run_next;
  end
endmodule : spc_periph_gate

// *** hdl/spc_ctrl.sv ***
// spc_ctrl: sleep/idle power-save sequencer
//
// How it works
// - sleep stops the system clock and turns off the on-chip oscillator.
// - fail-safe clock monitor is held off throughout sleep.
// - low-power rc clock runs in sleep when watchdog is enabled.
// - watchdog count cleared just before sleep entry when enabled.
// - system-clocked peripherals stop in sleep; externally clocked ones continue.
// - sleep ends on enabled interrupt, any reset, or watchdog time-out.
// - after sleep, the clock source selected at entry is restored.
// - standby select clear puts regulators in standby in sleep; low-power enable selects.
// - idle halts the processor, clock runs, peripherals continue unless disabled.
// - watchdog count cleared on idle entry.
// - low-power rc clock runs in idle if watchdog or clock monitor enabled.
// - idle ends on enabled interrupt, any reset, or watchdog time-out.
// - on idle wake, processor clock returns; execution resumes after a few cycles.
// - each peripheral has a stop-in-idle bit; timer bit is control bit 13.
// - interrupt during power-save instruction is held and wakes after entry.
`timescale 1ns/100ps
module spc_ctrl
  import spc_pkg::*;
(
  // clock and reset
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_i,
  // processor core request
  input  wire logic                    pwrsave_req_i,
  input  wire logic                    pwrsave_mode_i,
  output logic                         cpu_run_o,
  output logic                         resume_pulse_o,
  // wake sources
  input  wire logic                    irq_pending_i,
  input  wire logic                    wdt_timeout_i,
  input  wire logic                    ext_wake_async_i,
  // configuration
  input  wire logic                    watchdog_timer_en_i,
  input  wire logic                    fail_safe_clock_monitor_en_i,
  input  wire logic                    regulator_standby_select_i,
  input  wire logic                    low_power_regulator_enable_i,
  input  wire logic                    clk_src_sel_i,
  input  wire logic [15:0]             first_timer_control_i,
  input  wire logic [SPC_NPER-1:0]     periph_stop_in_idle_i,
  input  wire logic [SPC_NPER-1:0]     periph_ext_clocked_i,
  // clock and power controls
  output logic                         sys_clk_run_o,
  output logic                         osc_en_o,
  output logic                         clk_src_o,
  output logic                         fail_safe_clock_monitor_active_o,
  output logic                         low_power_rc_clock_en_o,
  output logic                         watchdog_timer_clear_o,
  output logic                         regulator_standby_o,
  output logic                         regulator_low_power_o,
  output logic [SPC_NPER-1:0]          periph_run_o,
  output logic                         first_timer_run_o,
  // status
  output logic                         in_sleep_o,
  output logic                         in_idle_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  spc_state_t  state_reg, state_next;
  logic        mode_reg;
  logic        clk_src_reg;
  logic        held_irq_reg;
  logic [2:0]  cnt_reg;
  logic        ext_wake_s;

  spc_sync2 u_wake_sync (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .d_i       (ext_wake_async_i),
    .q_o       (ext_wake_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire is_sleep   = (state_reg == SPC_SLEEP);
  wire is_idle    = (state_reg == SPC_IDLE);
  wire is_enter   = (state_reg == SPC_ENTER);
  wire low_pwr    = is_sleep || is_idle;
  // any wake source; held interrupt keeps one that hit during entry
  wire wake_any   = irq_pending_i || held_irq_reg || wdt_timeout_i || ext_wake_s;
  wire req_take   = (state_reg == SPC_RUN) && pwrsave_req_i;
  wire resume_end = (state_reg == SPC_RESUME) && (cnt_reg == SPC_CNT_ZERO);
  // gating follows the state being entered, so nothing lags the status flags by a cycle
  wire go_sleep   = (state_next == SPC_SLEEP);
  wire go_idle    = (state_next == SPC_IDLE);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SPC_RUN:    if (pwrsave_req_i) state_next = SPC_ENTER;
      SPC_ENTER:  state_next = (mode_reg == SPC_MODE_SLEEP) ? SPC_SLEEP : SPC_IDLE;
      SPC_SLEEP:  if (wake_any) state_next = SPC_RESUME;
      SPC_IDLE:   if (wake_any) state_next = SPC_RESUME;
      SPC_RESUME: if (cnt_reg == SPC_CNT_ZERO) state_next = SPC_RUN;
      default:    state_next = SPC_RUN;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers; reset is itself a wake, returning to run
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) state_reg <= SPC_RUN;
    else       state_reg <= state_next;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i)         mode_reg <= SPC_MODE_SLEEP;
    else if (req_take) mode_reg <= pwrsave_mode_i;
  end

  // clock source captured at entry and restored on wake
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i)         clk_src_reg <= SPC_CLKSEL_RST;
    else if (req_take) clk_src_reg <= clk_src_sel_i;
  end

  // interrupt arriving during entry is held until low-power state reached
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i)                             held_irq_reg <= 1'h0;
    else if ((req_take || is_enter) && irq_pending_i) held_irq_reg <= 1'h1;
    else if (low_pwr)                      held_irq_reg <= 1'h0;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i)                        cnt_reg <= SPC_CNT_ZERO;
    else if (low_pwr && wake_any)     cnt_reg <= SPC_RESUME_LAST;
    else if (cnt_reg != SPC_CNT_ZERO) cnt_reg <= cnt_reg - SPC_CNT_ONE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // peripheral gating
  for (genvar i = 0; i < SPC_NPER; i++) begin : g_per
    spc_periph_gate u_gate (
      .clk_sys_i      (clk_sys_i),
      .rst_i          (rst_i),
      .in_sleep_i     (go_sleep),
      .in_idle_i      (go_idle),
      .stop_in_idle_i (periph_stop_in_idle_i[i]),
      .ext_clocked_i  (periph_ext_clocked_i[i]),
      .run_o          (periph_run_o[i])
    );
  end

  spc_periph_gate u_tmr_gate (
    .clk_sys_i      (clk_sys_i),
    .rst_i          (rst_i),
    .in_sleep_i     (go_sleep),
    .in_idle_i      (go_idle),
    .stop_in_idle_i (first_timer_control_i[SPC_TMR_STOP_IN_IDLE_POS]),
    .ext_clocked_i  (1'h1),
    .run_o          (first_timer_run_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  wire low_power_rc_clock_next = go_sleep ? watchdog_timer_en_i
                 : go_idle  ? (watchdog_timer_en_i || fail_safe_clock_monitor_en_i)
                 : 1'h1;
  // clear pulse decoded on the entry cycle only, registered to land in the first cycle of the state
  wire wdt_clr_next = (state_next == SPC_SLEEP && watchdog_timer_en_i)
                   || (state_next == SPC_IDLE);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sys_clk_run_o           <= 1'h1;
      osc_en_o                <= 1'h1;
      clk_src_o               <= SPC_CLKSEL_RST;
      fail_safe_clock_monitor_active_o           <= 1'h0;
      low_power_rc_clock_en_o <= 1'h1;
      watchdog_timer_clear_o  <= 1'h0;
      regulator_standby_o     <= SPC_REG_STBY_RST;
      regulator_low_power_o   <= SPC_LPWR_RST;
      cpu_run_o               <= 1'h1;
      resume_pulse_o          <= 1'h0;
      in_sleep_o              <= 1'h0;
      in_idle_o               <= 1'h0;
    end else begin
      sys_clk_run_o           <= (state_next != SPC_SLEEP);
      osc_en_o                <= (state_next != SPC_SLEEP);
      clk_src_o               <= (state_next == SPC_RUN) ? clk_src_sel_i : clk_src_reg;
      fail_safe_clock_monitor_active_o           <= fail_safe_clock_monitor_en_i && !go_sleep;
      low_power_rc_clock_en_o <= low_power_rc_clock_next;
      watchdog_timer_clear_o  <= wdt_clr_next && is_enter;
      regulator_standby_o     <= go_sleep && !regulator_standby_select_i;
      regulator_low_power_o   <= low_power_regulator_enable_i;
      cpu_run_o               <= (state_next == SPC_RUN);
      resume_pulse_o          <= resume_end;
      in_sleep_o              <= (state_next == SPC_SLEEP);
      in_idle_o               <= (state_next == SPC_IDLE);
    end
  end

endmodule : spc_ctrl

// *** tb/spc_core_model.sv ***
// spc_core_model: processor core issuing the power-save instruction
`timescale 1ns/100ps
module spc_core_model (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  // bench command and core state
  input  wire logic go_i,
  input  wire logic mode_i,
  input  wire logic cpu_run_i,
  // power-save instruction
  output logic      req_o,
  output logic      mode_o
);
  // operand toggles outside a request so a stale value never looks valid
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      req_o  <= 1'h0;
      mode_o <= 1'h0;
    end else begin
      req_o  <= go_i && cpu_run_i;
      mode_o <= go_i ? mode_i : !mode_o;
    end
  end
endmodule : spc_core_model

// *** tb/spc_ctrl_props.sv ***
// spc_ctrl_props: checker for the power-save sequencer
`timescale 1ns/100ps
module spc_ctrl_props (
  // clock, reset, requests
  input wire logic clk_sys_i, rst_i, pwrsave_req_i, pwrsave_mode_i, irq_pending_i, wdt_timeout_i,
  // configuration
  input wire logic watchdog_timer_en_i, fail_safe_clock_monitor_en_i, regulator_standby_select_i,
  // outputs
  input wire logic cpu_run_o, resume_pulse_o, sys_clk_run_o, osc_en_o, clk_src_o, low_power_rc_clock_en_o,
  input wire logic watchdog_timer_clear_o, regulator_standby_o, in_sleep_o, in_idle_o, fail_safe_clock_monitor_active_o,
  // peripheral gating
  input wire logic [7:0] periph_ext_clocked_i,
  input wire logic [7:0] periph_run_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  wire logic saving = in_sleep_o || in_idle_o;
  ////////////////////////////////////////////////////////////////////////////////////////////////
  clk_off_a: assert property (in_sleep_o |-> !sys_clk_run_o && !osc_en_o) else $error("clock on in sleep");
  wdt_clear_a: assert property ($rose(in_idle_o) || $rose(in_sleep_o) && watchdog_timer_en_i |->
    watchdog_timer_clear_o) else $error("no watchdog clear");
  wake_src_a: assert property (saving && (irq_pending_i || wdt_timeout_i) |=> !saving)
    else $error("no wake");
  reg_stby_a: assert property (in_sleep_o && $past(in_sleep_o) |->
    regulator_standby_o != $past(regulator_standby_select_i)) else $error("bad regulator standby");
  rc_clock_a: assert property (saving && $past(saving) |-> low_power_rc_clock_en_o ==
    ($past(watchdog_timer_en_i) || in_idle_o && $past(fail_safe_clock_monitor_en_i))) else $error("bad rc clock");
  entry_mode_a: assert property (pwrsave_req_i && cpu_run_o |-> ##2 in_idle_o == $past(pwrsave_mode_i, 2)
    && in_sleep_o != $past(pwrsave_mode_i, 2)) else $error("wrong mode entered");
  resume_dly_a: assert property ($fell(saving) |-> !cpu_run_o [*3] ##1 (cpu_run_o && resume_pulse_o))
    else $error("bad resume delay");
  held_irq_a: assert property (pwrsave_req_i && cpu_run_o && irq_pending_i |-> ##2 saving ##1 !saving)
    else $error("held interrupt lost");
  src_hold_a: assert property (saving && $past(saving) |-> $stable(clk_src_o)) else $error("source moved");
  fail_safe_clock_monitor_off_a: assert property (in_sleep_o |-> !fail_safe_clock_monitor_active_o) else $error("monitor on in sleep");
  sleep_periph_a: assert property (in_sleep_o |-> periph_run_o == $past(periph_ext_clocked_i))
    else $error("bad peripheral gating in sleep");
  cover property (pwrsave_req_i && irq_pending_i);
  cover property ($rose(in_sleep_o));
  cover property ($rose(in_idle_o));
  cover property (resume_pulse_o);
endmodule : spc_ctrl_props
bind spc_ctrl spc_ctrl_props u_spc_ctrl_props (.*);

// *** tb/test_sleep_idle_power_control.sv ***
// test_sleep_idle_power_control: self-checking bench for spc_ctrl
`timescale 1ns/100ps
module test_sleep_idle_power_control;
  import spc_pkg::*;
  logic clk_sys_i, rst_i, pwrsave_req_i, pwrsave_mode_i, cpu_run_o, resume_pulse_o, irq_pending_i, go, md;
  logic wdt_timeout_i, ext_wake_async_i, watchdog_timer_en_i, fail_safe_clock_monitor_en_i, clk_src_sel_i;
  logic regulator_standby_select_i, low_power_regulator_enable_i, sys_clk_run_o, osc_en_o, clk_src_o;
  logic fail_safe_clock_monitor_active_o, low_power_rc_clock_en_o, watchdog_timer_clear_o, regulator_standby_o;
  logic regulator_low_power_o, first_timer_run_o, in_sleep_o, in_idle_o;
  logic [15:0]         first_timer_control_i;
  logic [SPC_NPER-1:0] periph_stop_in_idle_i, periph_ext_clocked_i, periph_run_o;
  int                  err_total = 0, n_tests = 0, cyc = 0, n;
  wire logic           saving = in_sleep_o || in_idle_o;
  spc_ctrl u_spc_ctrl (.*);
  spc_core_model u_spc_core_model (.clk_sys_i, .rst_i, .go_i(go), .mode_i(md), .cpu_run_i(cpu_run_o),
                                   .req_o(pwrsave_req_i), .mode_o(pwrsave_mode_i));
  initial begin
    clk_sys_i = 1'h0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  // a stuck sequence ends the run as a mismatch
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [SPC_NPER-1:0] got, input logic [SPC_NPER-1:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish
  // w: 0 interrupt, 1 watchdog time-out, 2 async wake, 3 reset, 4 interrupt during the instruction
  task automatic run_one(input int w);
    logic [4:0]  cf;
    logic [31:0] pv;
    logic        m;
    cf = 5'($urandom);
    pv = $urandom;
    m  = 1'($urandom);
    @(posedge clk_sys_i);
    {watchdog_timer_en_i, fail_safe_clock_monitor_en_i, regulator_standby_select_i,
     low_power_regulator_enable_i, clk_src_sel_i} <= cf;
    {periph_stop_in_idle_i, periph_ext_clocked_i, first_timer_control_i} <= pv;
    md <= m;
    go <= 1'h1;
    @(posedge clk_sys_i);
    go            <= 1'h0;
    irq_pending_i <= (w == 4);
    for (n = 0; n == 0 || (!saving && n < 8); n++)
      @(posedge clk_sys_i) #1;
    chk(in_idle_o, m, "mode");
    chk({sys_clk_run_o, osc_en_o}, {m, m}, "clocks");
    chk(watchdog_timer_clear_o, m | cf[4], "watchdog clear");
    if (w != 4) begin
      @(posedge clk_sys_i) #1;
      chk({low_power_rc_clock_en_o, fail_safe_clock_monitor_active_o, regulator_standby_o, regulator_low_power_o},
          {cf[4] || (m && cf[3]), m && cf[3], !m && !cf[2], cf[1]}, "clock and regulator");
      chk(periph_run_o, m ? ~pv[31:24] : pv[23:16], "peripherals");
      chk(first_timer_run_o || !m, !(m && pv[13]), "timer idle stop");
      @(posedge clk_sys_i);
      clk_src_sel_i <= !cf[0];
      {irq_pending_i, wdt_timeout_i, ext_wake_async_i, rst_i} <= 4'h8 >> w;
    end
    if (w == 3) begin
      repeat (2) @(posedge clk_sys_i);
      rst_i <= 1'h0;
      @(posedge clk_sys_i) #1;
      chk(cpu_run_o && !saving, 1'h1, "reset wake");
    end else begin
      for (n = 0; n == 0 || (saving && n < 8); n++)
        @(posedge clk_sys_i) #1;
      if (w != 2) chk(n, 1, "wake latency");
      chk(clk_src_o, cf[0], "entry clock source");
      for (n = 0; !cpu_run_o && n < 8; n++) begin
        @(posedge clk_sys_i);
        {irq_pending_i, wdt_timeout_i, ext_wake_async_i} <= 3'h0;
        #1;
      end
      chk(n, SPC_RESUME_CYC, "resume delay");
      chk(resume_pulse_o, 1'h1, "resume pulse");
    end
  endtask : run_one
  initial begin
    {rst_i, go, md, irq_pending_i, wdt_timeout_i, ext_wake_async_i} = 6'h20;
    {watchdog_timer_en_i, fail_safe_clock_monitor_en_i, regulator_standby_select_i} = 3'h0;
    {low_power_regulator_enable_i, clk_src_sel_i} = 2'h0;
    {periph_stop_in_idle_i, periph_ext_clocked_i, first_timer_control_i} = 32'h0;
    void'($urandom(51));
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'h0;
    for (int i = 0; i < 30; i++)
      run_one(i % 5);
    tally_and_finish();
  end
endmodule : test_sleep_idle_power_control
